// ===== logic/rpm_ctrl.v
// power mode decoder, rectifier target selection and packet pacing
//
// How it works
// - output current is sorted into four bands of the maximum current
// - each band maps to a rectifier target of 7.08, 6.28, 5.53 or 5.11 V
// - hardware current clamp equals 1.2 times the maximum current
// - after an input surge, control-error packets go out every 30 ms
// - once rectifier is back on target, packets go out every 250 ms
// - above overvoltage threshold the regulator is off, transmitter told
// - both mode-select pins have pulldowns; open pins select adapter mode
// - low-low: adapter present turns gate on and wireless off
// - low-high: communication limit off, wireless has priority
// - first pin low: wired and wireless allowed, no end-power packet
// - high-low: gate off, wireless off, back-powering on, no-response end
// - high-high: all paths off, no output, terminating end-power packet
// - communication current limit only enabled in low-low mode
// - end-power packets carry header 0x02 then a reason code
`timescale 1ns/1ps
`default_nettype none
`include "rpm_regs.vh"

module rpm_ctrl #(
  parameter [17:0] MS_CYCLES = `RPM_CLK_KHZ * `RPM_TICK_MS
) (
  input  wire        clk,
  input  wire        reset_n,
  // register port
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdata,
  output wire        irq,
  // pins and comparators
  input  wire        modeSelectA,
  input  wire        modeSelectB,
  output wire        modeSelectPullEn,
  input  wire        adapterAboveThreshold,
  input  wire        inputSurge,
  input  wire        rectAtTarget,
  input  wire        rectAboveOvp,
  input  wire [15:0] outputCurrent,
  // power path
  output reg         adapterGateOn,
  output reg         wirelessEnable,
  output reg         wiredEnable,
  output reg         wirelessPriority,
  output reg         otgEnable,
  output reg         commLimitEnable,
  output reg         regulatorEnable,
  output reg  [15:0] hardwareCurrentClamp,
  output reg  [15:0] rectTargetMv,
  // packets to the modulator
  output reg         pktValid,
  input  wire        pktReady,
  output reg  [7:0]  pktHeader,
  output reg  [15:0] pktData
);

  localparam [2:0] ST_OFF  = 3'b001;
  localparam [2:0] ST_FAST = 3'b010;
  localparam [2:0] ST_SLOW = 3'b100;

  // ========================================================================
  // pin synchronisers
  reg  [5:0] syncA_q;
  reg  [5:0] syncB_q;
  wire       modeA    = syncB_q[0];
  wire       modeB    = syncB_q[1];
  wire       adapter  = syncB_q[2];
  wire       surge    = syncB_q[3];
  wire       atTarget = syncB_q[4];
  wire       overVolt = syncB_q[5];

  assign modeSelectPullEn = 1'b1;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= 6'h00;
      syncB_q <= 6'h00;
    end else begin
      syncA_q <= {rectAboveOvp, rectAtTarget, inputSurge,
                  adapterAboveThreshold, modeSelectB, modeSelectA};
      syncB_q <= syncA_q;
    end
  end

  // ========================================================================
  // mode debounce
  reg  [1:0] modeRaw_q;
  reg  [1:0] mode_q;
  reg  [3:0] debCnt_q;
  reg        modeChg_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      modeRaw_q <= 2'b00;
      mode_q    <= 2'b00;
      debCnt_q  <= 4'h0;
      modeChg_q <= 1'b0;
    end else begin
      modeRaw_q <= {modeA, modeB};
      modeChg_q <= 1'b0;
      if (modeRaw_q != {modeA, modeB}) begin
        debCnt_q <= 4'h0;
      end else if (debCnt_q != `RPM_DEBOUNCE) begin
        debCnt_q <= debCnt_q + 4'h1;
      end else if (mode_q != modeRaw_q) begin
        mode_q    <= modeRaw_q;
        modeChg_q <= 1'b1;
      end
    end
  end

  // ========================================================================
  // power path decode
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adapterGateOn    <= 1'b0;
      wirelessEnable   <= 1'b0;
      wiredEnable      <= 1'b0;
      wirelessPriority <= 1'b0;
      otgEnable        <= 1'b0;
      commLimitEnable  <= 1'b0;
    end else begin
      case (mode_q)
        2'b00: begin
          adapterGateOn    <= adapter;
          wirelessEnable   <= ~adapter;
          wiredEnable      <= 1'b1;
          wirelessPriority <= 1'b0;
          otgEnable        <= 1'b0;
          commLimitEnable  <= 1'b1;
        end
        2'b01: begin
          adapterGateOn    <= 1'b0;
          wirelessEnable   <= 1'b1;
          wiredEnable      <= 1'b1;
          wirelessPriority <= 1'b1;
          otgEnable        <= 1'b0;
          commLimitEnable  <= 1'b0;
        end
        2'b10: begin
          adapterGateOn    <= 1'b0;
          wirelessEnable   <= 1'b0;
          wiredEnable      <= 1'b1;
          wirelessPriority <= 1'b0;
          otgEnable        <= 1'b1;
          commLimitEnable  <= 1'b0;
        end
        default: begin
          adapterGateOn    <= 1'b0;
          wirelessEnable   <= 1'b0;
          wiredEnable      <= 1'b0;
          wirelessPriority <= 1'b0;
          otgEnable        <= 1'b0;
          commLimitEnable  <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // current bands and rectifier target
  reg  [15:0] maxCur_q;
  reg  [1:0]  band_q;
  reg         bandChg_q;
  wire [19:0] iout20 = {4'h0, outputCurrent};
  wire [19:0] imax20 = {4'h0, maxCur_q};
  wire        le10   = (iout20 * `RPM_MUL_10PCT) <= imax20;
  wire        le20   = (iout20 * `RPM_MUL_20PCT) <= imax20;
  wire        le40   = (iout20 * `RPM_MUL_40PCT_I) <=
                       (imax20 * `RPM_MUL_40PCT_M);
  wire [19:0] clamp20 = (imax20 * `RPM_CLAMP_NUM) / `RPM_CLAMP_DEN;
  reg  [1:0]  bandD;
  reg  [15:0] tgtD;

  always @* begin
    if (le10) begin
      bandD = 2'd0;
    end else if (le20) begin
      bandD = 2'd1;
    end else if (le40) begin
      bandD = 2'd2;
    end else begin
      bandD = 2'd3;
    end
    case (band_q)
      2'd0:    tgtD = `RPM_TGT_BAND0;
      2'd1:    tgtD = `RPM_TGT_BAND1;
      2'd2:    tgtD = `RPM_TGT_BAND2;
      default: tgtD = `RPM_TGT_BAND3;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      band_q               <= 2'd0;
      bandChg_q            <= 1'b0;
      rectTargetMv         <= `RPM_TGT_BAND0;
      hardwareCurrentClamp <= 16'h0000;
    end else begin
      band_q               <= bandD;
      bandChg_q            <= (bandD != band_q);
      rectTargetMv         <= tgtD;
      hardwareCurrentClamp <= clamp20[15:0];
    end
  end

  // ========================================================================
  // packet pacing
  reg  [2:0]  state_q;
  reg  [17:0] msCnt_q;
  reg  [7:0]  ivCnt_q;
  reg         surgeD_q;
  reg         ovpD_q;
  wire        msTick   = (msCnt_q == MS_CYCLES - 18'd1);
  wire        surgeEvt = surge & ~surgeD_q;
  wire        ovpEvt   = overVolt & ~ovpD_q;
  wire [7:0]  ivLen    = (state_q == ST_FAST) ? `RPM_FAST_MS : `RPM_SLOW_MS;
  wire        ceDue    = msTick & (ivCnt_q >= ivLen - 8'd1);
  reg         cePend_q;
  reg         eptPend_q;
  reg  [7:0]  eptReason_q;
  reg         eptSent;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q         <= ST_OFF;
      msCnt_q         <= 18'd0;
      ivCnt_q         <= 8'd0;
      surgeD_q        <= 1'b0;
      ovpD_q          <= 1'b0;
      regulatorEnable <= 1'b0;
    end else begin
      surgeD_q        <= surge;
      ovpD_q          <= overVolt;
      regulatorEnable <= wirelessEnable & ~overVolt & (mode_q != 2'b11);
      if (msTick) begin
        msCnt_q <= 18'd0;
      end else begin
        msCnt_q <= msCnt_q + 18'd1;
      end
      if (ceDue) begin
        ivCnt_q <= 8'd0;
      end else if (msTick) begin
        ivCnt_q <= ivCnt_q + 8'd1;
      end
      case (state_q)
        ST_OFF: begin
          if (wirelessEnable) begin
            state_q <= ST_SLOW;
            ivCnt_q <= 8'd0;
          end
        end
        ST_FAST: begin
          if (!wirelessEnable) begin
            state_q <= ST_OFF;
          end else if (atTarget && !overVolt) begin
            state_q <= ST_SLOW;
          end
        end
        ST_SLOW: begin
          if (!wirelessEnable) begin
            state_q <= ST_OFF;
          end else if (surgeEvt || overVolt) begin
            state_q <= ST_FAST;
            ivCnt_q <= 8'd0;
          end
        end
        default: state_q <= ST_OFF;
      endcase
    end
  end

  // end-power reason decision, packet mux; end-power wins over control error
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cePend_q    <= 1'b0;
      eptPend_q   <= 1'b0;
      eptReason_q <= 8'h00;
      pktValid    <= 1'b0;
      pktHeader   <= 8'h00;
      pktData     <= 16'h0000;
      eptSent     <= 1'b0;
    end else begin
      eptSent <= 1'b0;
      if (modeChg_q && mode_q[1]) begin
        eptPend_q   <= 1'b1;
        eptReason_q <= mode_q[0] ? `RPM_EPT_CHGDONE : `RPM_EPT_NORESP;
      end
      if (ceDue && state_q != ST_OFF) begin
        cePend_q <= 1'b1;
      end
      if (pktValid) begin
        if (pktReady) begin
          pktValid <= 1'b0;
          eptSent  <= (pktHeader == `RPM_HDR_EPT);
        end
      end else if (eptPend_q && !(modeChg_q && mode_q[1])) begin
        pktValid  <= 1'b1;
        pktHeader <= `RPM_HDR_EPT;
        pktData   <= {8'h00, eptReason_q};
        eptPend_q <= 1'b0;
      end else if (cePend_q && !ceDue) begin
        pktValid  <= 1'b1;
        pktHeader <= `RPM_HDR_CE;
        pktData   <= rectTargetMv;
        cePend_q  <= 1'b0;
      end
    end
  end

  // ========================================================================
  // registers and interrupts
  reg  [4:0] irqStat_q;
  reg  [4:0] irqEn_q;
  wire [4:0] irqSet = {surgeEvt, eptSent, bandChg_q, modeChg_q, ovpEvt};
  wire [4:0] irqClr = (regWrite && regAddr == `RPM_ADDR_IRQCLR) ?
                      regWdata[4:0] : 5'h00;

  assign irq = |(irqStat_q & irqEn_q);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      maxCur_q  <= `RPM_MAXCUR_RST;
      irqEn_q   <= `RPM_IRQEN_RST;
      irqStat_q <= 5'h00;
      regRdata  <= 32'h0000_0000;
    end else begin
      irqStat_q <= (irqStat_q & ~irqClr) | irqSet;
      if (regWrite && regAddr == `RPM_ADDR_MAXCUR) begin
        maxCur_q <= regWdata[15:0];
      end
      if (regWrite && regAddr == `RPM_ADDR_IRQEN) begin
        irqEn_q <= regWdata[4:0];
      end
      regRdata <= 32'h0000_0000;
      if (regRead) begin
        case (regAddr)
          `RPM_ADDR_MAXCUR:  regRdata <= {16'h0000, maxCur_q};
          `RPM_ADDR_STATUS:  regRdata <= {18'h00000, regulatorEnable,
                                         wirelessEnable, adapterGateOn,
                                         otgEnable, commLimitEnable,
                                         state_q, band_q, mode_q,
                                         wirelessPriority, wiredEnable};
          `RPM_ADDR_IRQSTAT: regRdata <= {27'h0000000, irqStat_q};
          `RPM_ADDR_IRQEN:   regRdata <= {27'h0000000, irqEn_q};
          `RPM_ADDR_CLAMP:   regRdata <= {16'h0000, hardwareCurrentClamp};
          default:           regRdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ===== logic/rpm_regs.vh
// register map, field codes and timing constants of the power mode controller
`ifndef RPM_REGS_VH
`define RPM_REGS_VH

// ==========================================================================
// register offsets (byte addresses)
`define RPM_ADDR_MAXCUR   8'h00
`define RPM_ADDR_STATUS   8'h04
`define RPM_ADDR_IRQSTAT  8'h08
`define RPM_ADDR_IRQCLR   8'h0c
`define RPM_ADDR_IRQEN    8'h10
`define RPM_ADDR_CLAMP    8'h14

// ==========================================================================
// reset values
`define RPM_MAXCUR_RST    16'h03e8
`define RPM_IRQEN_RST     5'h00

// ==========================================================================
// interrupt bits
`define RPM_IRQ_OVP       0
`define RPM_IRQ_MODE      1
`define RPM_IRQ_BAND      2
`define RPM_IRQ_EPT       3
`define RPM_IRQ_SURGE     4
`define RPM_IRQ_W         5

// ==========================================================================
// band scaling: percent thresholds as multipliers on current
`define RPM_MUL_10PCT     20'h0000a
`define RPM_MUL_20PCT     20'h00005
`define RPM_MUL_40PCT_I   20'h00005
`define RPM_MUL_40PCT_M   20'h00002
`define RPM_CLAMP_NUM     20'h0000c
`define RPM_CLAMP_DEN     20'h0000a

// rectifier targets in millivolts, lowest band first
`define RPM_TGT_BAND0     16'h1ba8
`define RPM_TGT_BAND1     16'h1888
`define RPM_TGT_BAND2     16'h159a
`define RPM_TGT_BAND3     16'h13f6

// ==========================================================================
// packet headers and end-power reasons
`define RPM_HDR_EPT       8'h02
`define RPM_HDR_CE        8'h03
`define RPM_EPT_CHGDONE   8'h01
`define RPM_EPT_NORESP    8'h08

// ==========================================================================
// timing
`define RPM_CLK_KHZ       18'h3d090
`define RPM_TICK_MS       18'h00001
`define RPM_FAST_MS       8'd30
`define RPM_SLOW_MS       8'd250
`define RPM_DEBOUNCE      4'hf

`endif

// ===== verification/rpm_ctrl_assertions.sv
// port assertions for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module rpm_ctrl_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        modeSelectA,
  input wire logic        modeSelectB,
  input wire logic        modeSelectPullEn,
  input wire logic        rectAboveOvp,
  input wire logic [15:0] outputCurrent,
  input wire logic        adapterGateOn,
  input wire logic        wirelessEnable,
  input wire logic        wiredEnable,
  input wire logic        wirelessPriority,
  input wire logic        otgEnable,
  input wire logic        commLimitEnable,
  input wire logic        regulatorEnable,
  input wire logic [15:0] rectTargetMv,
  input wire logic        pktValid,
  input wire logic        pktReady,
  input wire logic [7:0]  pktHeader,
  input wire logic [15:0] pktData
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ==========
  // cycles the mode pins have held one level
  logic [4:0] pinCnt_q;
  logic [1:0] pins_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pinCnt_q <= 5'h00;
      pins_q   <= 2'h0;
    end else begin
      pins_q <= {modeSelectA, modeSelectB};
      if (pins_q != {modeSelectA, modeSelectB}) pinCnt_q <= 5'h00;
      else if (pinCnt_q != 5'h1f) pinCnt_q <= pinCnt_q + 5'h01;
    end
  end
  // ==========
  // properties
  sequence pktHeld; pktValid && !pktReady; endsequence
  sequence pktTaken; pktValid && pktReady; endsequence
  sequence ovpSeen; rectAboveOvp [*4]; endsequence
  pull_enable_a: assert property (modeSelectPullEn)
    else $error("mode pin pulldown off");
  target_legal_a: assert property (rectTargetMv inside
    {16'h1ba8, 16'h1888, 16'h159a, 16'h13f6})
    else $error("illegal rectifier target");
  low_band_a: assert property ((outputCurrent == 16'h0000) [*4]
    |-> rectTargetMv == 16'h1ba8) else $error("zero load not lowest band");
  comm_limit_a: assert property (commLimitEnable |->
    !wirelessPriority && !otgEnable && wiredEnable)
    else $error("comm limit outside adapter mode");
  wireless_first_a: assert property (wirelessPriority |->
    wirelessEnable && !commLimitEnable) else $error("priority mode wrong");
  otg_mode_a: assert property (otgEnable |->
    !adapterGateOn && !wirelessEnable && wiredEnable)
    else $error("back-power mode wrong");
  gate_excl_a: assert property (adapterGateOn |-> !wirelessEnable)
    else $error("gate on with wireless on");
  shutdown_mode_a: assert property (pinCnt_q >= 5'd24 &&
    pins_q == 2'b11 |-> !wirelessEnable && !wiredEnable && !adapterGateOn)
    else $error("shutdown mode leaves a path on");
  ovp_reg_off_a: assert property (ovpSeen |=> !regulatorEnable)
    else $error("regulator on above overvoltage");
  pkt_hold_a: assert property (pktHeld |=> pktValid &&
    $stable(pktHeader) && $stable(pktData)) else $error("packet dropped");
  pkt_drop_a: assert property (pktTaken |=> !pktValid)
    else $error("packet repeated");
  ept_format_a: assert property (pktValid && pktHeader == 8'h02
    |-> pktData inside {16'h0001, 16'h0008}) else $error("bad end packet");
endmodule
`default_nettype wire

// ===== verification/rpm_ctrl_test.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module rpm_ctrl_test;
  logic        clk, reset_n, regWrite, regRead, irq, modeSelectA;
  logic        modeSelectB, modeSelectPullEn, adapterAboveThreshold;
  logic        inputSurge, rectAtTarget, rectAboveOvp, adapterGateOn;
  logic        wirelessEnable, wiredEnable, wirelessPriority, otgEnable;
  logic        commLimitEnable, regulatorEnable, pktValid, pktReady;
  logic        holdOff;
  logic [7:0]  regAddr, pktHeader;
  logic [31:0] regWdata, regRdata;
  logic [15:0] outputCurrent, hardwareCurrentClamp, rectTargetMv, pktData;
  logic [15:0] ceData, eptData;
  int          ceCount, eptCount, ceGap;
  int          failures = 0;
  int          totalChecks = 0;
  rpm_ctrl #(.MS_CYCLES(18'd10)) u_dut (.clk, .reset_n, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .irq, .modeSelectA,
    .modeSelectB, .modeSelectPullEn, .adapterAboveThreshold, .inputSurge,
    .rectAtTarget, .rectAboveOvp, .outputCurrent, .adapterGateOn,
    .wirelessEnable, .wiredEnable, .wirelessPriority, .otgEnable,
    .commLimitEnable, .regulatorEnable, .hardwareCurrentClamp,
    .rectTargetMv, .pktValid, .pktReady, .pktHeader, .pktData);
  rpm_pkt_sink u_sink (.clk, .holdOff, .pktValid, .pktReady, .pktHeader,
    .pktData, .ceCount, .eptCount, .ceGap, .ceData, .eptData);
  // ==========
  // shared tasks
  task automatic chk(input string n, input logic [31:0] got, exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic waitCe(input int k, input int lim);
    int t;
    t = ceCount + k;
    for (int i = 0; i < lim && ceCount < t; i++) @(posedge clk);
    chk("ceArrived", 32'(ceCount >= t), 32'h1);
  endtask
  // ==========
  // scenarios
  task automatic test_regs();
    logic [31:0] d;
    rd(8'h14, d);
    chk("clampRst", d, 32'h4b0);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h64);
    repeat (3) @(posedge clk);
    #1 chk("clampPort", 32'(hardwareCurrentClamp), 32'h78);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
  endtask
  task automatic test_bands();
    logic [15:0] cur [6] = '{16'd10, 16'd11, 16'd20, 16'd21, 16'd40, 16'd41};
    logic [15:0] mv [6] = '{16'h1ba8, 16'h1888, 16'h1888, 16'h159a,
                            16'h159a, 16'h13f6};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      outputCurrent <= cur[i];
      repeat (4) @(posedge clk);
      #1 chk("target", 32'(rectTargetMv), 32'(mv[i]));
    end
  endtask
  task automatic test_modes();
    logic [2:0] pin [5] = '{3'b000, 3'b001, 3'b011, 3'b101, 3'b111};
    logic [5:0] exp [5] = '{6'h19, 6'h29, 6'h1c, 6'h0a, 6'h00};
    logic [7:0] end_power_packet [5] = '{8'h0, 8'h0, 8'h0, 8'h8, 8'h1};
    logic [5:0] got;
    int n;
    logic [31:0] d;
    @(posedge clk);
    modeSelectB <= 1'b1;
    repeat (5) @(posedge clk);
    modeSelectB <= 1'b0;
    repeat (30) @(posedge clk);
    rd(8'h08, d);
    chk("glitchIgnored", 32'(d[1]), 32'h0);
    for (int i = 0; i < 5; i++) begin
      n = eptCount;
      @(posedge clk);
      modeSelectA <= pin[i][2];
      modeSelectB <= pin[i][1];
      adapterAboveThreshold <= pin[i][0];
      repeat (40) @(posedge clk);
      #1 got = {adapterGateOn, wirelessEnable, wiredEnable,
                wirelessPriority, otgEnable, commLimitEnable};
      chk("powerPath", 32'(got), 32'(exp[i]));
      chk("eptSent", eptCount - n, 32'(end_power_packet[i] != 0));
      if (end_power_packet[i] != 0) chk("eptData", 32'(eptData), 32'(end_power_packet[i]));
    end
  endtask
  task automatic test_pacing();
    @(posedge clk);
    modeSelectA <= 1'b0;
    waitCe(2, 9000);
    chk("slowGap", ceGap, 2500);
    inputSurge <= 1'b1;
    waitCe(2, 9000);
    chk("fastGap", ceGap, 300);
    chk("ceData", 32'(ceData), 32'h13f6);
    rectAtTarget <= 1'b1;
    waitCe(2, 9000);
    chk("backSlowGap", ceGap, 2500);
  endtask
  task automatic test_ovp();
    logic [31:0] d;
    wr(8'h10, 32'h1);
    @(posedge clk);
    rectAboveOvp <= 1'b1;
    waitCe(1, 320);
    chk("regOff", 32'(regulatorEnable), 32'h0);
    chk("irqHigh", 32'(irq), 32'h1);
    holdOff <= 1'b1;
    repeat (350) @(posedge clk);
    holdOff <= 1'b0;
    waitCe(1, 5);
    rectAboveOvp <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("regOn", 32'(regulatorEnable), 32'h1);
    rd(8'h08, d);
    chk("ovpSticky", 32'(d[0]), 32'h1);
    wr(8'h10, 32'h0);
    chk("irqMasked", 32'(irq), 32'h0);
    wr(8'h10, 32'h1);
    chk("irqUnmasked", 32'(irq), 32'h1);
    wr(8'h0c, 32'h1);
    chk("irqCleared", 32'(irq), 32'h0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // clock, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {reset_n, regWrite, regRead, modeSelectA, modeSelectB} = 5'h00;
    {adapterAboveThreshold, inputSurge, rectAtTarget} = 3'h0;
    {rectAboveOvp, holdOff, regAddr, regWdata} = 42'h0;
    outputCurrent = 16'h0000;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    test_regs();
    test_bands();
    test_modes();
    test_pacing();
    test_ovp();
    report_and_stop();
  end
  initial begin
    #200000;
    failures++;
    report_and_stop();
  end
endmodule
bind rpm_ctrl rpm_ctrl_checker u_chk (.clk, .reset_n, .modeSelectA,
  .modeSelectB, .modeSelectPullEn, .rectAboveOvp, .outputCurrent,
  .adapterGateOn, .wirelessEnable, .wiredEnable, .wirelessPriority,
  .otgEnable, .commLimitEnable, .regulatorEnable, .rectTargetMv,
  .pktValid, .pktReady, .pktHeader, .pktData);
`default_nettype wire

// ===== verification/rpm_pkt_sink.sv
// transmitter side: takes packets and logs the spacing of control-error packets
`timescale 1ns/1ps
`default_nettype none
module rpm_pkt_sink (
  input  wire logic        clk,
  input  wire logic        holdOff,
  input  wire logic        pktValid,
  output wire logic        pktReady,
  input  wire logic [7:0]  pktHeader,
  input  wire logic [15:0] pktData,
  output var  int          ceCount,
  output var  int          eptCount,
  output var  int          ceGap,
  output var  logic [15:0] ceData,
  output var  logic [15:0] eptData
);
  int now = 0;
  int lastCe = 0;
  initial begin
    ceCount  = 0;
    eptCount = 0;
    ceGap    = 0;
  end
  // ==========
  // holdOff models a slow demodulator
  assign pktReady = !holdOff;
  always @(posedge clk) begin
    now <= now + 1;
    if (pktValid && pktReady) begin
      if (pktHeader == 8'h02) begin
        eptCount <= eptCount + 1;
        eptData  <= pktData;
      end else begin
        ceCount <= ceCount + 1;
        ceGap   <= now - lastCe;
        lastCe  <= now;
        ceData  <= pktData;
      end
    end
  end
endmodule
`default_nettype wire
